// ==== logic/line_ctrl_pkg.sv ====
// Shared constants and types for the line loopback and store control block.
// Assumes a byte-wide host port and one 125 MHz clock.
package line_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] LOOP_CONTROL_ADDR = 8'h14;
  localparam logic [7:0] RECEIVE_STORE_CONTROL_ADDR = 8'h15;
  localparam logic [7:0] LINE_DRIVER_CONTROL_ADDR = 8'h16;

  // Reset values.
  localparam logic [7:0] LOOP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RECEIVE_STORE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] LINE_DRIVER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field positions.
  localparam int NEAR_LOOP_BIT = 6;
  localparam int LINE_IFACE_RESET_BIT = 7;
  localparam int STORE_ALIGN_BIT = 6;
  localparam int STORE_RESET_BIT = 5;
  localparam int MONITOR_CHAN_MSB = 4;
  localparam int MONITOR_CHAN_LSB = 0;
  localparam int OPEN_DRAIN_BIT = 7;
  localparam int DISCONNECT_BIT = 6;
  localparam int SYNC_IFACE_BIT = 5;
  localparam int RX_TERM_BIT = 4;
  localparam int TX_PRBS_HI = 3;
  localparam int TX_PRBS_LO = 2;
  localparam int RX_PRBS_HI = 1;
  localparam int RX_PRBS_LO = 0;
  localparam int CMD_W = 3;

  // One bipolar line symbol.
  typedef struct packed {
    logic pos;
    logic neg;
  } line_pair_t;

  // Drive of one line pin: value and active-low enable.
  typedef struct packed {
    logic value;
    logic oe_n;
  } pin_drive_t;

endpackage

// ==== logic/cmd_edge_strobe.sv ====
// Rising-edge detector for command bits held in a control register.
// Assumes the bits change only on host writes in the same clock domain.
module cmd_edge_strobe #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Command bits and strobes
  input wire logic [WIDTH-1:0] cmd_level,
  output logic [WIDTH-1:0] cmd_pulse
);

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic [WIDTH-1:0] pulse_reg;
  logic [WIDTH-1:0] pulse_next;

  // Each bit only fires on 0 to 1, so holding it high never repeats.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        prev_next[i] = cmd_level[i];
        pulse_next[i] = cmd_level[i] & ~prev_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prev_reg <= '0;
      pulse_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign cmd_pulse = pulse_reg;

  property p_single_pulse;
    @(posedge ref_clk) disable iff (reset)
      pulse_reg != '0 |=> (pulse_reg & $past(pulse_reg)) == '0;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("command strobe lasted more than one cycle");

endmodule

// ==== logic/line_loopback_store_control.sv ====
// Control registers, local loopback and line drive for one line channel.
// Assumes a synchronous byte host port and a bit enable from the line clock.

// Function
// - In local loopback the normal transmit data still goes out the line.
// - In local loopback transmitted data replaces the receiver input.
// - Looped data passes the jitter attenuator on its way to receive.
// - Line reset bit rising resets clock recovery and attenuator once.
// - Align bit rising centres store pointers at half frame when closer.
// - Align does nothing when pointers are already half a frame apart.
// - Store reset bit rising sets store depth to one frame, losing data.
// - Bits 4 to 0 select the receive channel shown by the monitor.
// - Open-drain bit makes the transmit line outputs open drain.
// - Disconnect bit sends an unframed 1010 pattern instead of data.
// - Sync interface bit with sync select picks line or sync signalling.
// - Termination bit switches in internal parallel resistance.
// - Bits 3 and 2 hold the transmit PRBS mode, bit 3 upper.
// - Bits 1 and 0 hold the receive PRBS mode, bit 1 upper.
// - Bit 6 of the register at 14h enables local loopback.
// - Sync decode: 00 normal, 01 transmit only, 10 both, 11 receive only.
module line_loopback_store_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Host register port
  input wire logic [line_ctrl_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_wr,
  input wire logic [line_ctrl_pkg::DATA_W-1:0] host_wdata,
  output logic [line_ctrl_pkg::DATA_W-1:0] host_rdata,
  // Line data
  input wire logic bit_en,
  input wire line_ctrl_pkg::line_pair_t tx_data,
  input wire line_ctrl_pkg::line_pair_t rx_line,
  output line_ctrl_pkg::pin_drive_t tx_line_pos,
  output line_ctrl_pkg::pin_drive_t tx_line_neg,
  output line_ctrl_pkg::line_pair_t jitter_atten_in,
  // Elastic store and line interface commands
  input wire logic store_sep_ge_half,
  output logic line_iface_reset_pulse,
  output logic store_align_pulse,
  output logic store_reset_pulse,
  // Static controls
  input wire logic tx_sync_select,
  output logic [4:0] rx_monitor_chan,
  output logic tx_sync_mode,
  output logic rx_sync_mode,
  output logic rx_termination_select,
  output logic [1:0] tx_prbs_mode,
  output logic [1:0] rx_prbs_mode
);
  import line_ctrl_pkg::*;

  logic [7:0] loop_control_reg, loop_control_next;
  logic [7:0] receive_store_control_reg, receive_store_control_next;
  logic [7:0] line_driver_control_reg, line_driver_control_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [CMD_W-1:0] cmd_pulse;
  logic near_loop_enable, driver_open_drain, disconnect_pattern_gen;
  logic sync_interface_enable;
  logic [1:0] phase_reg, phase_next;
  line_pair_t tx_sym, ja_reg, ja_next;
  pin_drive_t pos_reg, pos_next, neg_reg, neg_next;
  logic align_reg, align_next;
  logic tx_sync_reg, tx_sync_next, rx_sync_reg, rx_sync_next;

  // Register writes and read-back.
  always_comb begin
    loop_control_next = loop_control_reg;
    receive_store_control_next = receive_store_control_reg;
    line_driver_control_next = line_driver_control_reg;
    if (host_wr) begin
      unique case (host_addr)
        LOOP_CONTROL_ADDR: begin
          loop_control_next = 8'h00;
          loop_control_next[NEAR_LOOP_BIT] = host_wdata[NEAR_LOOP_BIT];
        end
        RECEIVE_STORE_CONTROL_ADDR: begin
          receive_store_control_next = host_wdata;
        end
        LINE_DRIVER_CONTROL_ADDR: begin
          line_driver_control_next = host_wdata;
        end
        default: begin
        end
      endcase
    end
    unique case (host_addr)
      LOOP_CONTROL_ADDR: rdata_next = loop_control_reg;
      RECEIVE_STORE_CONTROL_ADDR: rdata_next = receive_store_control_reg;
      LINE_DRIVER_CONTROL_ADDR: rdata_next = line_driver_control_reg;
      default: rdata_next = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      loop_control_reg <= LOOP_CONTROL_RESET;
      receive_store_control_reg <= RECEIVE_STORE_CONTROL_RESET;
      line_driver_control_reg <= LINE_DRIVER_CONTROL_RESET;
      rdata_reg <= UNMAPPED_READ;
    end else begin
      loop_control_reg <= loop_control_next;
      receive_store_control_reg <= receive_store_control_next;
      line_driver_control_reg <= line_driver_control_next;
      rdata_reg <= rdata_next;
    end
  end

  assign near_loop_enable = loop_control_reg[NEAR_LOOP_BIT];
  assign driver_open_drain = line_driver_control_reg[OPEN_DRAIN_BIT];
  assign disconnect_pattern_gen = line_driver_control_reg[DISCONNECT_BIT];
  assign sync_interface_enable = line_driver_control_reg[SYNC_IFACE_BIT];

  cmd_edge_strobe #(
    .WIDTH(CMD_W)
  ) cmd_edge_strobe_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .cmd_level({receive_store_control_reg[LINE_IFACE_RESET_BIT],
                receive_store_control_reg[STORE_ALIGN_BIT],
                receive_store_control_reg[STORE_RESET_BIT]}),
    .cmd_pulse(cmd_pulse)
  );

  // Align strobe is held back one extra cycle so it can be qualified here.
  always_comb begin
    align_next = cmd_pulse[1] & ~store_sep_ge_half;
  end

  // Line data path, advanced once per line bit.
  always_comb begin
    phase_next = phase_reg;
    ja_next = ja_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    tx_sym = tx_data;
    if (disconnect_pattern_gen) begin
      // Marks alternate polarity so the pattern stays DC balanced.
      tx_sym.pos = (phase_reg == 2'd0);
      tx_sym.neg = (phase_reg == 2'd2);
    end
    if (bit_en) begin
      phase_next = phase_reg + 2'd1;
      // Loop data feeds the attenuator input, never the receive path direct.
      ja_next = near_loop_enable ? tx_sym : rx_line;
      if (driver_open_drain) begin
        // Open drain only ever pulls low; a mark releases nothing.
        pos_next = '{value: 1'b0, oe_n: ~tx_sym.pos};
        neg_next = '{value: 1'b0, oe_n: ~tx_sym.neg};
      end else begin
        pos_next = '{value: tx_sym.pos, oe_n: 1'b0};
        neg_next = '{value: tx_sym.neg, oe_n: 1'b0};
      end
    end
    // Sync signalling decode of the two select bits.
    unique case ({sync_interface_enable, tx_sync_select})
      2'b00: {tx_sync_next, rx_sync_next} = 2'b00;
      2'b01: {tx_sync_next, rx_sync_next} = 2'b10;
      2'b10: {tx_sync_next, rx_sync_next} = 2'b11;
      2'b11: {tx_sync_next, rx_sync_next} = 2'b01;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_reg <= 2'd0;
      ja_reg <= '0;
      pos_reg <= '{value: 1'b0, oe_n: 1'b1};
      neg_reg <= '{value: 1'b0, oe_n: 1'b1};
      align_reg <= 1'b0;
      tx_sync_reg <= 1'b0;
      rx_sync_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      ja_reg <= ja_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      align_reg <= align_next;
      tx_sync_reg <= tx_sync_next;
      rx_sync_reg <= rx_sync_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign tx_line_pos = pos_reg;
  assign tx_line_neg = neg_reg;
  assign jitter_atten_in = ja_reg;
  assign line_iface_reset_pulse = cmd_pulse[2];
  assign store_align_pulse = align_reg;
  assign store_reset_pulse = cmd_pulse[0];
  assign tx_sync_mode = tx_sync_reg;
  assign rx_sync_mode = rx_sync_reg;
  assign rx_monitor_chan =
    receive_store_control_reg[MONITOR_CHAN_MSB:MONITOR_CHAN_LSB];
  assign rx_termination_select =
    line_driver_control_reg[RX_TERM_BIT];
  assign tx_prbs_mode =
    line_driver_control_reg[TX_PRBS_HI:TX_PRBS_LO];
  assign rx_prbs_mode =
    line_driver_control_reg[RX_PRBS_HI:RX_PRBS_LO];

  sequence s_store_write(int b);
    host_wr && host_addr == RECEIVE_STORE_CONTROL_ADDR && host_wdata[b]
      && !receive_store_control_reg[b];
  endsequence

  property p_line_reset;
    @(posedge ref_clk) disable iff (reset)
      s_store_write(LINE_IFACE_RESET_BIT) |-> ##2 line_iface_reset_pulse
        ##1 !line_iface_reset_pulse;
  endproperty
  a_line_reset: assert property (p_line_reset)
    else $error("line reset strobe missing or too long");

  property p_align_gated;
    @(posedge ref_clk) disable iff (reset)
      s_store_write(STORE_ALIGN_BIT) ##2 store_sep_ge_half
        |=> !store_align_pulse;
  endproperty
  a_align_gated: assert property (p_align_gated)
    else $error("align issued with pointers already apart");

  property p_align_fires;
    @(posedge ref_clk) disable iff (reset)
      s_store_write(STORE_ALIGN_BIT) ##2 !store_sep_ge_half
        |=> store_align_pulse;
  endproperty
  a_align_fires: assert property (p_align_fires)
    else $error("align not issued on close pointers");

  property p_store_reset;
    @(posedge ref_clk) disable iff (reset)
      s_store_write(STORE_RESET_BIT) |-> ##2 store_reset_pulse;
  endproperty
  a_store_reset: assert property (p_store_reset)
    else $error("store reset strobe missing");

  property p_loop_path;
    @(posedge ref_clk) disable iff (reset)
      bit_en && near_loop_enable && !disconnect_pattern_gen
        |=> jitter_atten_in == $past(tx_data);
  endproperty
  a_loop_path: assert property (p_loop_path)
    else $error("loopback did not route transmit data");

  property p_tx_normal;
    @(posedge ref_clk) disable iff (reset)
      bit_en && !disconnect_pattern_gen && !driver_open_drain
        |=> tx_line_pos.value == $past(tx_data.pos) && !tx_line_pos.oe_n;
  endproperty
  a_tx_normal: assert property (p_tx_normal)
    else $error("transmit data altered");

  property p_open_drain;
    @(posedge ref_clk) disable iff (reset)
      bit_en && driver_open_drain |=> !tx_line_pos.value && !tx_line_neg.value;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_sync_decode;
    @(posedge ref_clk) disable iff (reset)
      sync_interface_enable && !tx_sync_select
        |=> tx_sync_mode && rx_sync_mode;
  endproperty
  a_sync_decode: assert property (p_sync_decode)
    else $error("sync decode wrong for both-sides case");

  property p_monitor;
    @(posedge ref_clk) disable iff (reset)
      host_wr && host_addr == RECEIVE_STORE_CONTROL_ADDR
        |=> rx_monitor_chan == $past(host_wdata[4:0]);
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor channel not updated");

endmodule

// ==== verif/host_port_model.sv ====
// Host processor model that drives the byte register port of the block.
// Assumes one bench clock; every request changes on a falling edge.
module host_port_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [line_ctrl_pkg::ADDR_W-1:0] host_addr,
  output logic host_wr,
  output logic [line_ctrl_pkg::DATA_W-1:0] host_wdata,
  input wire logic [line_ctrl_pkg::DATA_W-1:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import line_ctrl_pkg::*;

  initial begin
    host_addr = 8'hFF;
    host_wr = 1'b0;
    host_wdata = 8'h00;
  end

  // Write data is inverted once the strobe drops, so stale data never
  // looks like a valid second write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask

  // Read data is registered, so it is taken one cycle after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a;
    @(negedge ref_clk);
    d = host_rdata;
  endtask
endmodule

// ==== verif/test_line_loopback_store_control.sv ====
// Self-checking bench for the line loopback and store control block.
// Assumes the host model above; inputs change on falling clock edges.
module test_line_loopback_store_control;
  timeunit 1ns;
  timeprecision 1ps;
  import line_ctrl_pkg::*;

  logic ref_clk, reset, host_wr, bit_en, store_sep_ge_half, tx_sync_select;
  logic [7:0] host_addr, host_wdata, host_rdata, v;
  line_pair_t tx_data, rx_line, jitter_atten_in;
  pin_drive_t tx_line_pos, tx_line_neg;
  logic line_iface_reset_pulse, store_align_pulse, store_reset_pulse;
  logic [4:0] rx_monitor_chan;
  logic tx_sync_mode, rx_sync_mode, rx_termination_select;
  logic [1:0] tx_prbs_mode, rx_prbs_mode;
  int errors, compares, n_lir, n_al, n_rs, mp, mn;
  logic [7:0] addrs [4] = '{8'h14, 8'h15, 8'h16, 8'h17};
  logic [7:0] cmds [5] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20};
  logic [7:0] pulses [5] = '{8'h04, 8'h00, 8'h02, 8'h00, 8'h01};
  logic clr [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic sep [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  host_port_model host_port_model_i (.ref_clk(ref_clk),
    .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata));

  line_loopback_store_control line_loopback_store_control_i (
    .ref_clk(ref_clk), .reset(reset), .host_addr(host_addr),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .bit_en(bit_en), .tx_data(tx_data), .rx_line(rx_line),
    .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg),
    .jitter_atten_in(jitter_atten_in),
    .store_sep_ge_half(store_sep_ge_half),
    .line_iface_reset_pulse(line_iface_reset_pulse),
    .store_align_pulse(store_align_pulse),
    .store_reset_pulse(store_reset_pulse),
    .tx_sync_select(tx_sync_select), .rx_monitor_chan(rx_monitor_chan),
    .tx_sync_mode(tx_sync_mode), .rx_sync_mode(rx_sync_mode),
    .rx_termination_select(rx_termination_select),
    .tx_prbs_mode(tx_prbs_mode), .rx_prbs_mode(rx_prbs_mode));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Strobes stand one cycle, so each is counted at the edge that ends it.
  always @(posedge ref_clk) begin
    if (line_iface_reset_pulse === 1'b1) n_lir++;
    if (store_align_pulse === 1'b1) n_al++;
    if (store_reset_pulse === 1'b1) n_rs++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bit_step(input line_pair_t t, input line_pair_t r);
    @(negedge ref_clk);
    tx_data = t;
    rx_line = r;
    bit_en = 1'b1;
    @(negedge ref_clk);
    bit_en = 1'b0;
  endtask

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    errors++;
    finish_test();
  end

  initial begin
    reset = 1'b1;
    bit_en = 1'b0;
    tx_data = 2'b00;
    rx_line = 2'b00;
    store_sep_ge_half = 1'b0;
    tx_sync_select = 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host_port_model_i.rd(addrs[i], v);
      chk(v, 8'h00);
    end
    $display("test reset values done");
    host_port_model_i.wr(LOOP_CONTROL_ADDR, 8'hFF);
    host_port_model_i.rd(LOOP_CONTROL_ADDR, v);
    chk(v, 8'h40);
    host_port_model_i.wr(RECEIVE_STORE_CONTROL_ADDR, 8'h1F);
    host_port_model_i.rd(RECEIVE_STORE_CONTROL_ADDR, v);
    chk({3'b000, rx_monitor_chan}, 8'h1F);
    chk(v, 8'h1F);
    host_port_model_i.wr(LINE_DRIVER_CONTROL_ADDR, 8'h1B);
    host_port_model_i.rd(LINE_DRIVER_CONTROL_ADDR, v);
    chk(v, 8'h1B);
    chk({3'b000, rx_termination_select, tx_prbs_mode, rx_prbs_mode},
        8'h1B);
    $display("test register fields done");
    // Commands go only after reset with the clock running.
    for (int i = 0; i < 5; i++) begin
      if (clr[i]) host_port_model_i.wr(RECEIVE_STORE_CONTROL_ADDR, 8'h00);
      store_sep_ge_half = sep[i];
      repeat (4) @(negedge ref_clk);
      n_lir = 0;
      n_al = 0;
      n_rs = 0;
      host_port_model_i.wr(RECEIVE_STORE_CONTROL_ADDR, cmds[i]);
      repeat (6) @(negedge ref_clk);
      chk(8'(n_lir * 4 + n_al * 2 + n_rs),
          pulses[i]);
    end
    $display("test command strobes done");
    for (int i = 0; i < 4; i++) begin
      tx_sync_select = i[0];
      host_port_model_i.wr(LINE_DRIVER_CONTROL_ADDR, i[1] ? 8'h20 : 8'h00);
      repeat (2) @(negedge ref_clk);
      chk({6'b0, tx_sync_mode, rx_sync_mode},
          {6'b0, i[1] ^ i[0], i[1]});
    end
    $display("test sync decode done");
    host_port_model_i.wr(LINE_DRIVER_CONTROL_ADDR, 8'h00);
    host_port_model_i.wr(LOOP_CONTROL_ADDR, 8'h00);
    bit_step(2'b10, 2'b01);
    chk({6'b0, jitter_atten_in}, 8'h01);
    host_port_model_i.wr(LOOP_CONTROL_ADDR, 8'h40);
    bit_step(2'b10, 2'b01);
    chk({6'b0, jitter_atten_in}, 8'h02);
    chk({4'b0, tx_line_pos, tx_line_neg}, 8'h08);
    host_port_model_i.wr(LINE_DRIVER_CONTROL_ADDR, 8'h80);
    bit_step(2'b10, 2'b01);
    chk({4'b0, tx_line_pos, tx_line_neg}, 8'h01);
    host_port_model_i.wr(LINE_DRIVER_CONTROL_ADDR, 8'h40);
    mp = 0;
    mn = 0;
    for (int i = 0; i < 4; i++) begin
      bit_step(2'b00, 2'b00);
      if (tx_line_pos.value === 1'b1) mp++;
      if (tx_line_neg.value === 1'b1) mn++;
    end
    chk(8'(mp * 16 + mn), 8'h11);
    $display("test line path done");
    finish_test();
  end
endmodule
